// file: rtl/asspc_defines.vh
// Offsets, fields, reset values and timing counts for the alarm stop and power sag controller
`ifndef ASSPC_DEFINES_VH
`define ASSPC_DEFINES_VH
`define ASSPC_CLK_HZ 100000000
`define ASSPC_TICK_MS 1
`define ASSPC_MS_CYCLES ((`ASSPC_CLK_HZ / 1000) * `ASSPC_TICK_MS)
`define ASSPC_OFF_STOP_CFG 12'h000
`define ASSPC_OFF_HOLD_TIME 12'h004
`define ASSPC_OFF_SAG_CFG 12'h008
`define ASSPC_OFF_CTRL 12'h00c
`define ASSPC_OFF_STATUS 12'h010
`define ASSPC_PRI_LSB 0
`define ASSPC_G2_BIT 4
`define ASSPC_UVA_LSB 8
`define ASSPC_PRI_RST 2'h0
`define ASSPC_G2_RST 1'b0
`define ASSPC_UVA_RST 2'h0
`define ASSPC_HOLD_RST 10'h014
`define ASSPC_HOLD_MIN 10'h014
`define ASSPC_HOLD_MAX 10'h3e8
`define ASSPC_SAG_LIM_RST 7'h32
`define ASSPC_SAG_LIM_MAX 7'h64
`define ASSPC_SAG_REL_RST 10'h064
`define ASSPC_SAG_REL_MAX 10'h3e8
`define ASSPC_FULL_TORQUE 7'h64
`define ASSPC_MODE_POS 2'h0
`define ASSPC_MODE_SPD 2'h1
`define ASSPC_MODE_TRQ 2'h2
`define ASSPC_ST_RUN 3'h0
`define ASSPC_ST_DB_STOP 3'h1
`define ASSPC_ST_COAST_STOP 3'h2
`define ASSPC_ST_ZERO_STOP 3'h3
`define ASSPC_ST_HELD_DB 3'h4
`define ASSPC_ST_HELD_COAST 3'h5
`endif

// file: rtl/asspc_top.v
// Alarm stopping, power-cut ride-through and undervoltage torque limit sequencing
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "asspc_defines.vh"
module asspc_top (
    input wire clk_i,
    input wire sys_rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire [1:0] control_mode_i,
    input wire alarm_group_one_i,
    input wire alarm_group_two_i,
    input wire motor_stopped_i,
    input wire main_power_lost_i,
    input wire control_supply_lost_i,
    input wire undervoltage_alarm_i,
    input wire dc_bus_undervoltage_i,
    output reg motor_power_on_o,
    output reg dynamic_brake_o,
    output reg zero_speed_stop_o,
    output reg servo_ready_o,
    output reg undervoltage_warning_o,
    output reg [6:0] torque_limit_o
);
    // Encoded stop style: bit0 = brake while stopping, bit1 = brake after stopping
    function [1:0] stop_style;
        input [1:0] pri;
        begin
            case (pri)
                2'h0: stop_style = 2'h3;
                2'h1: stop_style = 2'h1;
                default: stop_style = 2'h0;
            endcase
        end
    endfunction

    // Stop state entered for a given style
    function [2:0] stop_entry;
        input [1:0] sty;
        begin
            stop_entry = sty[0] ? `ASSPC_ST_DB_STOP : `ASSPC_ST_COAST_STOP;
        end
    endfunction

    // State kept once the motor has come to rest
    function [2:0] held_entry;
        input [1:0] sty;
        begin
            held_entry = sty[1] ? `ASSPC_ST_HELD_DB : `ASSPC_ST_HELD_COAST;
        end
    endfunction

    // Register index of a bus address; 7 marks an unmapped address
    function [2:0] reg_index;
        input [11:0] addr;
        begin
            case (addr)
                `ASSPC_OFF_STOP_CFG: reg_index = 3'h0;
                `ASSPC_OFF_HOLD_TIME: reg_index = 3'h1;
                `ASSPC_OFF_SAG_CFG: reg_index = 3'h2;
                `ASSPC_OFF_CTRL: reg_index = 3'h3;
                `ASSPC_OFF_STATUS: reg_index = 3'h4;
                default: reg_index = 3'h7;
            endcase
        end
    endfunction

    // Pins from the power stage are asynchronous; two flops each
    localparam NSYNC = 7;
    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] sync1_q;
    reg [NSYNC-1:0] sync2_q;
    assign raw_in = {alarm_group_one_i, alarm_group_two_i, motor_stopped_i, main_power_lost_i,
                     control_supply_lost_i, undervoltage_alarm_i, dc_bus_undervoltage_i};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    wire alm1_s = sync2_q[6];
    wire alm2_s = sync2_q[5];
    wire stopped_s = sync2_q[4];
    wire lost_s = sync2_q[3];
    wire ctrl_lost_s = sync2_q[2];
    wire uv_alarm_s = sync2_q[1];
    wire uv_bus_s = sync2_q[0];


    // Registers
    reg [1:0] pri_q;
    reg g2_q;
    reg [9:0] hold_q;
    reg [1:0] uva_q;
    reg [6:0] sag_lim_q;
    reg [9:0] sag_rel_q;
    reg servo_on_q;
    reg servo_off_pulse_q;
    reg cut_expired_q;

    wire apb_acc = psel_i & penable_i & ~pready_o;
    wire wr = apb_acc & pwrite_i;
    wire known = (reg_index(paddr_i) != 3'h7);

    reg [2:0] st_q;
    reg [31:0] rd_d;

    always @* begin
        rd_d = 32'h0000_0000;
        case (paddr_i)
            `ASSPC_OFF_STOP_CFG: begin
                rd_d[`ASSPC_PRI_LSB+1:`ASSPC_PRI_LSB] = pri_q;
                rd_d[`ASSPC_G2_BIT] = g2_q;
                rd_d[`ASSPC_UVA_LSB+1:`ASSPC_UVA_LSB] = uva_q;
            end
            `ASSPC_OFF_HOLD_TIME: rd_d[9:0] = hold_q;
            `ASSPC_OFF_SAG_CFG: rd_d = {6'h00, sag_rel_q, 9'h000, sag_lim_q};
            `ASSPC_OFF_CTRL: rd_d[0] = servo_on_q;
            `ASSPC_OFF_STATUS: begin
                rd_d[0] = motor_power_on_o;
                rd_d[1] = dynamic_brake_o;
                rd_d[2] = servo_ready_o;
                rd_d[3] = undervoltage_warning_o;
                rd_d[6:4] = st_q;
                rd_d[13:7] = torque_limit_o;
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // One-wait-state APB slave; out-of-range settings are clamped to the legal span
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pri_q <= `ASSPC_PRI_RST;
            g2_q <= `ASSPC_G2_RST;
            uva_q <= `ASSPC_UVA_RST;
            hold_q <= `ASSPC_HOLD_RST;
            sag_lim_q <= `ASSPC_SAG_LIM_RST;
            sag_rel_q <= `ASSPC_SAG_REL_RST;
            servo_on_q <= 1'b0;
            servo_off_pulse_q <= 1'b0;
        end else begin
            pready_o <= apb_acc;
            pslverr_o <= apb_acc & ~known;
            prdata_o <= (apb_acc & ~pwrite_i) ? rd_d : 32'h0000_0000;
            servo_off_pulse_q <= 1'b0;
            if (wr) begin
                case (paddr_i)
                    `ASSPC_OFF_STOP_CFG: begin
                        pri_q <= (pwdata_i[`ASSPC_PRI_LSB+1:`ASSPC_PRI_LSB] == 2'h3) ? 2'h2 :
                                 pwdata_i[`ASSPC_PRI_LSB+1:`ASSPC_PRI_LSB];
                        g2_q <= pwdata_i[`ASSPC_G2_BIT];
                        uva_q <= (pwdata_i[`ASSPC_UVA_LSB+1:`ASSPC_UVA_LSB] == 2'h3) ? 2'h2 :
                                 pwdata_i[`ASSPC_UVA_LSB+1:`ASSPC_UVA_LSB];
                    end
                    `ASSPC_OFF_HOLD_TIME: begin
                        if (pwdata_i[31:0] < {22'h0, `ASSPC_HOLD_MIN})
                            hold_q <= `ASSPC_HOLD_MIN;
                        else if (pwdata_i[31:0] > {22'h0, `ASSPC_HOLD_MAX})
                            hold_q <= `ASSPC_HOLD_MAX;
                        else
                            hold_q <= pwdata_i[9:0];
                    end
                    `ASSPC_OFF_SAG_CFG: begin
                        sag_lim_q <= (pwdata_i[15:0] > {9'h0, `ASSPC_SAG_LIM_MAX}) ?
                                     `ASSPC_SAG_LIM_MAX : pwdata_i[6:0];
                        sag_rel_q <= (pwdata_i[31:16] > {6'h0, `ASSPC_SAG_REL_MAX}) ?
                                     `ASSPC_SAG_REL_MAX : pwdata_i[25:16];
                    end
                    `ASSPC_OFF_CTRL: begin
                        servo_on_q <= pwdata_i[0];
                        servo_off_pulse_q <= servo_on_q & ~pwdata_i[0];
                    end
                    default: servo_on_q <= servo_on_q;
                endcase
            end
        end
    end

    // Millisecond tick shared by hold-time and release-time counters
    // Divider end point cut to the counter width on purpose
    localparam [31:0] MS_LAST = `ASSPC_MS_CYCLES - 1;
    wire [16:0] ms_last = MS_LAST[16:0];
    reg [16:0] div_q;
    reg tick_q;
    wire div_wrap = (div_q == ms_last);

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= 17'h00000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= div_wrap;
            div_q <= div_wrap ? 17'h00000 : div_q + 17'h00001;
        end
    end

    // Power-cut ride-through
    reg [9:0] cut_ms_q;
    wire ride_abort = ctrl_lost_s | uv_alarm_s;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cut_ms_q <= 10'h000;
            cut_expired_q <= 1'b0;
        end else if (!lost_s) begin
            cut_ms_q <= 10'h000;
            cut_expired_q <= 1'b0;
        end else if (ride_abort) begin
            cut_expired_q <= 1'b1;
        end else if (tick_q && !cut_expired_q) begin
            cut_ms_q <= cut_ms_q + 10'h001;
            if (cut_ms_q >= hold_q)
                cut_expired_q <= 1'b1;
        end
    end

    // Alarm stop sequencer; a cut that outlasts the hold while running also enters the stop chosen by pri_q
    wire g2_as_g1 = g2_q | (control_mode_i == `ASSPC_MODE_TRQ);
    wire [1:0] style = stop_style(pri_q);

    reg [2:0] st_d;
    always @* begin
        st_d = st_q;
        case (st_q)
            `ASSPC_ST_RUN: begin
                if (alm1_s || (alm2_s && g2_as_g1) || !servo_on_q || cut_expired_q)
                    st_d = stop_entry(style);
                else if (alm2_s)
                    st_d = `ASSPC_ST_ZERO_STOP;
            end
            `ASSPC_ST_ZERO_STOP: begin
                if (alm1_s || servo_off_pulse_q)
                    st_d = stop_entry(style);
                else if (stopped_s)
                    st_d = held_entry(style);
            end
            `ASSPC_ST_DB_STOP, `ASSPC_ST_COAST_STOP: begin
                if (stopped_s)
                    st_d = held_entry(style);
            end
            `ASSPC_ST_HELD_DB, `ASSPC_ST_HELD_COAST: begin
                if (servo_on_q && !alm1_s && !alm2_s && !cut_expired_q)
                    st_d = `ASSPC_ST_RUN;
            end
            default: st_d = `ASSPC_ST_RUN;
        endcase
    end

    // Undervoltage torque limit with linear release back to full torque
    reg [9:0] rel_ms_q;
    reg releasing_q;
    reg [6:0] lim_d;
    wire uv_en = (uva_q != 2'h0);
    wire [16:0] ramp = {10'h0, `ASSPC_FULL_TORQUE - sag_lim_q} * {7'h0, rel_ms_q};
    // Quotient never exceeds the sag gap; a zero release time never takes this path
    wire [16:0] ramp_step = ramp / {7'h0, sag_rel_q};

    always @* begin
        if (uva_q != 2'h2 || (!uv_bus_s && !releasing_q))
            lim_d = `ASSPC_FULL_TORQUE;
        else if (uv_bus_s || sag_rel_q == 10'h000)
            lim_d = uv_bus_s ? sag_lim_q : `ASSPC_FULL_TORQUE;
        else
            lim_d = sag_lim_q + ramp_step[6:0];
    end

    // Every top output is registered so the power stage sees no decode glitches

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= `ASSPC_ST_RUN;
            motor_power_on_o <= 1'b0;
            dynamic_brake_o <= 1'b0;
            zero_speed_stop_o <= 1'b0;
            servo_ready_o <= 1'b0;
            undervoltage_warning_o <= 1'b0;
            torque_limit_o <= `ASSPC_FULL_TORQUE;
        end else begin
            st_q <= st_d;
            motor_power_on_o <= servo_on_q && !servo_off_pulse_q && !cut_expired_q &&
                                (st_d == `ASSPC_ST_RUN || st_d == `ASSPC_ST_ZERO_STOP);
            dynamic_brake_o <= (st_d == `ASSPC_ST_DB_STOP) || (st_d == `ASSPC_ST_HELD_DB);
            zero_speed_stop_o <= (st_d == `ASSPC_ST_ZERO_STOP);
            servo_ready_o <= !cut_expired_q && !alm1_s && !alm2_s;
            undervoltage_warning_o <= uv_en && uv_bus_s;
            torque_limit_o <= lim_d;
        end
    end

    // Release timer runs only after a device-limited sag has cleared
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rel_ms_q <= 10'h000;
            releasing_q <= 1'b0;
        end else if (uva_q != 2'h2 || uv_bus_s) begin
            releasing_q <= uv_bus_s && (uva_q == 2'h2);
            rel_ms_q <= 10'h000;
        end else if (releasing_q && tick_q) begin
            if (rel_ms_q >= sag_rel_q - 10'h001 || sag_rel_q == 10'h000)
                releasing_q <= 1'b0;
            else
                rel_ms_q <= rel_ms_q + 10'h001;
        end
    end

endmodule
`default_nettype wire

// file: verif/asspc_top_chk.sv
// Port checks for the alarm stop and power sag controller
`timescale 1ns/1ns
`default_nettype none
module asspc_top_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic main_power_lost_i,
    input wire logic control_supply_lost_i,
    input wire logic undervoltage_alarm_i,
    input wire logic dc_bus_undervoltage_i,
    input wire logic motor_power_on_o,
    input wire logic servo_ready_o,
    input wire logic undervoltage_warning_o,
    input wire logic [6:0] torque_limit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready stretched");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("prdata outside answer");
    chk_supply_cut: assert property (
        $rose(control_supply_lost_i) && main_power_lost_i |-> ##[1:8] !motor_power_on_o)
        else $error("power kept after supply loss");
    chk_alarm_cut: assert property (
        $rose(undervoltage_alarm_i) && main_power_lost_i |-> ##[1:8] !motor_power_on_o)
        else $error("power kept after undervoltage alarm");
    chk_ready_drop: assert property (
        $rose(control_supply_lost_i) && main_power_lost_i |-> ##[1:8] !servo_ready_o)
        else $error("ready kept after expiry");
    chk_ride_through: assert property ($rose(main_power_lost_i) && motor_power_on_o
        && !control_supply_lost_i && !undervoltage_alarm_i |=> motor_power_on_o [*8])
        else $error("power cut before hold time");
    chk_warn_cause: assert property (
        $rose(undervoltage_warning_o) |-> $past(dc_bus_undervoltage_i, 3))
        else $error("warning without low bus");
    chk_limit_cause: assert property (
        $past(torque_limit_o) == 7'h64 && torque_limit_o != 7'h64 |-> undervoltage_warning_o)
        else $error("limit applied without warning");
endmodule
bind asspc_top asspc_top_chk asspc_top_chk_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .main_power_lost_i(main_power_lost_i),
    .control_supply_lost_i(control_supply_lost_i),
    .undervoltage_alarm_i(undervoltage_alarm_i),
    .dc_bus_undervoltage_i(dc_bus_undervoltage_i),
    .motor_power_on_o(motor_power_on_o),
    .servo_ready_o(servo_ready_o),
    .undervoltage_warning_o(undervoltage_warning_o),
    .torque_limit_o(torque_limit_o)
);
`default_nettype wire

// file: verif/asspc_host.sv
// Host controller model applying its own torque limit on warnings
`timescale 1ns/1ns
`default_nettype none
module asspc_host (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic undervoltage_warning_i,
    output logic [6:0] host_torque_limit_o
);
    // Limit held until the warning clears, so a returning supply sees no surge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            host_torque_limit_o <= 7'h64;
        end else begin
            host_torque_limit_o <= undervoltage_warning_i ? 7'h28 : 7'h64;
        end
    end
endmodule
`default_nettype wire

// file: verif/test_alarm_stop_and_power_sag_control.sv
// Self-checking bench for the alarm stop and power sag controller
`timescale 1ns/1ns
`default_nettype none
module test_alarm_stop_and_power_sag_control;
    logic clk_i = 1'h0, sys_rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, r;
    logic [1:0] control_mode_i = 2'h0;
    // Motor starts at rest so the stop entered with the servo off after reset settles into a held state
    logic alarm_group_one_i = 1'h0, alarm_group_two_i = 1'h0, motor_stopped_i = 1'h1;
    logic main_power_lost_i = 1'h0, control_supply_lost_i = 1'h0, undervoltage_alarm_i = 1'h0;
    logic dc_bus_undervoltage_i = 1'h0, pready_o, pslverr_o, err, motor_power_on_o;
    logic dynamic_brake_o, zero_speed_stop_o, servo_ready_o, undervoltage_warning_o;
    logic [6:0] torque_limit_o, host_lim;
    int error_cnt = 0, tests_run = 0;
    // Columns: primary[8:7] group_two_sel[6] mode[5:4] group[3] brake zero held[2:0]
    logic [8:0] rows [10] = '{9'h005, 9'h084, 9'h100, 9'h00b, 9'h09a, 9'h10a, 9'h04d,
        9'h0dc, 9'h148, 9'h02d};
    asspc_top asspc_top_inst (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .control_mode_i(control_mode_i),
        .alarm_group_one_i(alarm_group_one_i),
        .alarm_group_two_i(alarm_group_two_i),
        .motor_stopped_i(motor_stopped_i),
        .main_power_lost_i(main_power_lost_i),
        .control_supply_lost_i(control_supply_lost_i),
        .undervoltage_alarm_i(undervoltage_alarm_i),
        .dc_bus_undervoltage_i(dc_bus_undervoltage_i),
        .motor_power_on_o(motor_power_on_o),
        .dynamic_brake_o(dynamic_brake_o),
        .zero_speed_stop_o(zero_speed_stop_o),
        .servo_ready_o(servo_ready_o),
        .undervoltage_warning_o(undervoltage_warning_o),
        .torque_limit_o(torque_limit_o)
    );
    asspc_host asspc_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .undervoltage_warning_i(undervoltage_warning_o), .host_torque_limit_o(host_lim));
    always #5 clk_i = ~clk_i;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Slave answers after one wait state, but the bound is kept loose
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'h1 && n < 20);
        if (pready_o !== 1'h1) begin
            error_cnt++;
            $display("MISMATCH t=%0t no bus answer", $time);
            close_out();
        end
        r = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    task automatic wait_pwr(input logic v);
        int n;
        n = 0;
        while (motor_power_on_o !== v && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        cmp(32'(motor_power_on_o), 32'(v));
        if (n >= 50) close_out();
    endtask
    initial begin
        int i;
        repeat (5) @(posedge clk_i);
        cmp(32'(torque_limit_o), 32'h64);
        sys_rst_i <= 1'h0;
        apb(1'h0, 12'h004, 32'h0);
        cmp(r, 32'h14);
        apb(1'h0, 12'h008, 32'h0);
        cmp(r, 32'h00640032);
        apb(1'h0, 12'h020, 32'h0);
        cmp(r, 32'h0);
        cmp(32'(err), 32'h1);
        apb(1'h1, 12'h004, 32'h5);
        apb(1'h0, 12'h004, 32'h0);
        cmp(r, 32'h14);
        apb(1'h1, 12'h004, 32'h7d0);
        apb(1'h0, 12'h004, 32'h0);
        cmp(r, 32'h3e8);
        apb(1'h1, 12'h004, 32'h14);
        for (i = 0; i < 10; i++) begin
            apb(1'h1, 12'h000, {27'h0, rows[i][6], 2'h0, rows[i][8:7]});
            control_mode_i <= rows[i][5:4];
            motor_stopped_i <= 1'h0;
            apb(1'h1, 12'h00c, 32'h1);
            wait_pwr(1'h1);
            alarm_group_one_i <= ~rows[i][3];
            alarm_group_two_i <= rows[i][3];
            repeat (8) @(posedge clk_i);
            cmp({dynamic_brake_o, zero_speed_stop_o}, 32'(rows[i][2:1]));
            motor_stopped_i <= 1'h1;
            repeat (8) @(posedge clk_i);
            cmp(32'(dynamic_brake_o), 32'(rows[i][0]));
            alarm_group_one_i <= 1'h0;
            alarm_group_two_i <= 1'h0;
            apb(1'h1, 12'h00c, 32'h0);
        end
        apb(1'h1, 12'h00c, 32'h1);
        wait_pwr(1'h1);
        apb(1'h1, 12'h00c, 32'h0);
        @(posedge clk_i);
        cmp(32'(motor_power_on_o), 32'h0);
        for (i = 0; i < 2; i++) begin
            apb(1'h1, 12'h00c, 32'h1);
            wait_pwr(1'h1);
            main_power_lost_i <= 1'h1;
            repeat (20) @(posedge clk_i);
            cmp(32'(motor_power_on_o), 32'h1);
            control_supply_lost_i <= (i == 0);
            undervoltage_alarm_i <= (i == 1);
            wait_pwr(1'h0);
            cmp(32'(servo_ready_o), 32'h0);
            main_power_lost_i <= 1'h0;
            control_supply_lost_i <= 1'h0;
            undervoltage_alarm_i <= 1'h0;
            if (i == 0) wait_pwr(1'h1);
            apb(1'h1, 12'h00c, 32'h0);
        end
        // Zero release time keeps the ramp inside the run budget
        apb(1'h1, 12'h008, 32'h1e);
        for (i = 0; i < 3; i++) begin
            apb(1'h1, 12'h000, {22'h0, i[1:0], 8'h0});
            dc_bus_undervoltage_i <= 1'h1;
            repeat (8) @(posedge clk_i);
            cmp(32'(undervoltage_warning_o), 32'(i != 0));
            cmp(32'(torque_limit_o), (i == 2) ? 32'h1e : 32'h64);
            cmp(32'(host_lim), (i != 0) ? 32'h28 : 32'h64);
            dc_bus_undervoltage_i <= 1'h0;
            repeat (8) @(posedge clk_i);
            cmp(32'(torque_limit_o), 32'h64);
            cmp(32'(host_lim), 32'h64);
        end
        // Reset in mid-run must bring settings back to their defaults
        sys_rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        cmp({servo_ready_o, motor_power_on_o, torque_limit_o}, 32'h64);
        sys_rst_i <= 1'h0;
        apb(1'h0, 12'h008, 32'h0);
        cmp(r, 32'h00640032);
        cmp(32'(servo_ready_o), 32'h1);
        close_out();
    end
endmodule
`default_nettype wire
